// ---- src/crb_core_regs.sv ----
// Purpose: Dedicated CPU registers, program status, bank and direct-page address forming.
// Assumes: Decoder, ALU and APB master share the core clock; their inputs need no sync.
// Notes: Every output is a flip-flop; formed addresses appear one cycle after the request.
//
// Our own choices: the APB slave port and the address map.

module crb_core_regs
    import crb_pkg::*;
#(
    parameter logic [15:0] PROG_BASE = 16'h1000
) (
    input wire logic clock,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Decoder register writes and fetch step
    input wire logic core_wr_en,
    input wire crb_sel_t core_wr_sel,
    input wire logic [15:0] core_wr_data,
    input wire logic ip_step,
    // ALU operation on accumulator and temporary accumulator
    input wire logic alu_commit,
    input wire crb_alu_t alu_op,
    input wire logic alu_wide,
    // Address forming
    input wire logic addr_req,
    input wire logic addr_direct,
    input wire logic [7:0] addr_operand,
    // Interrupt request from the controller
    input wire logic irq_req,
    input wire logic [1:0] irq_level,
    // Register views
    output logic [15:0] instruction_pointer,
    output logic [15:0] accumulator,
    output logic [15:0] temp_accumulator,
    output logic [15:0] index_register,
    output logic [15:0] extra_pointer,
    output logic [15:0] stack_pointer,
    output logic [15:0] program_status,
    output logic [15:0] mem_addr,
    output logic mem_addr_valid,
    output crb_region_t mem_region,
    output logic irq_take
);

    // ----------------------------------------------------------------
    // Elaboration check
    // ----------------------------------------------------------------
    if (PROG_BASE <= IO_TOP || PROG_BASE >= VECTOR_BASE) begin : g_bad_prog_base
        $error("PROG_BASE must lie between the I/O area and the vector table");
    end

    crb_state_t q;
    crb_state_t d;

    // ALU working values
    logic [16:0] sum_w;
    logic [8:0] sum_b;
    logic [4:0] sum_n;
    logic [15:0] res;
    logic msb_a;
    logic msb_b;
    logic msb_r;
    logic carry;
    logic ovf;
    logic half;
    logic res_zero;
    // APB decode
    logic [31:0] rd_mux;
    logic rd_hit;
    logic apb_wr;
    // Address forming
    logic [3:0] page;
    logic [15:0] formed;

    // ----------------------------------------------------------------
    // ALU result and flags
    // ----------------------------------------------------------------
    // Add and subtract compute byte and word results, the width input picks one; shifts are byte only
    always_comb begin
        sum_w = 17'h00000;
        sum_b = 9'h000;
        sum_n = 5'h00;
        res = q.acc;
        carry = q.condition_flags[CCR_C];
        ovf = 1'b0;
        half = q.condition_flags[CCR_H];
        unique case (alu_op)
            ALU_ADD: begin
                sum_w = {1'b0, q.acc} + {1'b0, q.tmp};
                sum_b = {1'b0, q.acc[7:0]} + {1'b0, q.tmp[7:0]};
                sum_n = {1'b0, q.acc[3:0]} + {1'b0, q.tmp[3:0]};
            end
            ALU_SUB: begin
                sum_w = {1'b0, q.acc} - {1'b0, q.tmp};
                sum_b = {1'b0, q.acc[7:0]} - {1'b0, q.tmp[7:0]};
                sum_n = {1'b0, q.acc[3:0]} - {1'b0, q.tmp[3:0]};
            end
            ALU_SHL, ALU_SHR: begin
                sum_w = 17'h00000;
            end
        endcase
        msb_a = alu_wide ? q.acc[15] : q.acc[7];
        msb_b = alu_wide ? q.tmp[15] : q.tmp[7];
        unique case (alu_op)
            ALU_ADD, ALU_SUB: begin
                // Byte operations leave the accumulator high byte alone
                res = alu_wide ? sum_w[15:0] : {q.acc[15:8], sum_b[7:0]};
                carry = alu_wide ? sum_w[16] : sum_b[8];
                half = sum_n[4];
            end
            ALU_SHL: begin
                res = {q.acc[15:8], q.acc[6:0], 1'b0};
                carry = q.acc[7];
            end
            ALU_SHR: begin
                res = {q.acc[15:8], 1'b0, q.acc[7:1]};
                carry = q.acc[0];
            end
        endcase
        msb_r = (alu_wide && (alu_op == ALU_ADD || alu_op == ALU_SUB)) ? res[15] : res[7];
        // Add overflows on equal signs, subtract on differing signs
        if (alu_op == ALU_ADD) begin
            ovf = (msb_a == msb_b) && (msb_r != msb_a);
        end else if (alu_op == ALU_SUB) begin
            ovf = (msb_a != msb_b) && (msb_r != msb_a);
        end
        res_zero = (alu_wide && (alu_op == ALU_ADD || alu_op == ALU_SUB)) ?
            (res == ZERO16) : (res[7:0] == ZERO16[7:0]);
    end

    // ----------------------------------------------------------------
    // APB read decode
    // ----------------------------------------------------------------
    always_comb begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b1;
        unique case (paddr)
            OFS_IP: rd_mux = {ZERO16, q.ip};
            OFS_ACC: rd_mux = {ZERO16, q.acc};
            OFS_TMP: rd_mux = {ZERO16, q.tmp};
            OFS_IDX: rd_mux = {ZERO16, q.idx};
            OFS_EXT: rd_mux = {ZERO16, q.ext};
            OFS_SP: rd_mux = {ZERO16, q.sp};
            OFS_PS: rd_mux = {ZERO16, q.rp, q.dp, q.condition_flags};
            OFS_LAST: rd_mux = {ZERO16, q.mem_addr};
            default: rd_hit = 1'b0;
        endcase
    end

    // Write lands only at the access edge where pready is high
    assign apb_wr = psel && penable && pwrite && q.pready && rd_hit && (paddr != OFS_LAST);

    // ----------------------------------------------------------------
    // Address forming
    // ----------------------------------------------------------------
    // Page index is one above the selector, so zero maps the window onto itself
    always_comb begin
        page = {1'b0, q.dp} + PAGE_STEP;
        if (!addr_direct) begin
            formed = {BANK_BASE_HI, q.rp, addr_operand[2:0]};
        end else if (addr_operand < DIRECT_WINDOW) begin
            formed = {8'h00, addr_operand};
        end else begin
            formed = {5'h00, page, addr_operand[6:0]};
        end
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    // Core writes are applied after APB writes, so the core wins a same-cycle clash
    always_comb begin
        d = q;
        // APB slave: answer is prepared in the setup cycle, zero wait states
        d.pready = psel && !penable;
        d.pslverr = psel && !penable && (!rd_hit || (pwrite && paddr == OFS_LAST));
        d.prdata = (psel && !penable && !pwrite) ? rd_mux : q.prdata;
        if (apb_wr) begin
            unique case (paddr)
                OFS_IP: d.ip = pwdata[15:0];
                OFS_ACC: d.acc = pwdata[15:0];
                OFS_TMP: d.tmp = pwdata[15:0];
                OFS_IDX: d.idx = pwdata[15:0];
                OFS_EXT: d.ext = pwdata[15:0];
                OFS_SP: d.sp = pwdata[15:0];
                default: {d.rp, d.dp, d.condition_flags} = pwdata[15:0];
            endcase
        end
        // Fetch step advances the instruction pointer by one byte
        if (ip_step) begin
            d.ip = q.ip + 16'h0001;
        end
        if (core_wr_en) begin
            unique case (core_wr_sel)
                SEL_IP: d.ip = core_wr_data;
                SEL_ACC: d.acc = core_wr_data;
                SEL_TMP: d.tmp = core_wr_data;
                SEL_IDX: d.idx = core_wr_data;
                SEL_EXT: d.ext = core_wr_data;
                SEL_SP: d.sp = core_wr_data;
                SEL_PS: {d.rp, d.dp, d.condition_flags} = core_wr_data;
                default: d.acc = q.acc;
            endcase
        end
        // All flags of one operation move in the same edge as the result
        if (alu_commit) begin
            d.acc = res;
            d.condition_flags[CCR_N] = msb_r;
            d.condition_flags[CCR_Z] = res_zero;
            d.condition_flags[CCR_V] = ovf;
            d.condition_flags[CCR_C] = carry;
            d.condition_flags[CCR_H] = half;
        end
        // Formed address and its area
        d.mem_valid = addr_req;
        if (addr_req) begin
            d.mem_addr = formed;
            if (formed <= IO_TOP) begin
                d.region = REGION_IO;
            end else if (formed < PROG_BASE) begin
                d.region = REGION_DATA;
            end else if (formed < VECTOR_BASE) begin
                d.region = REGION_PROG;
            end else begin
                d.region = REGION_VECT;
            end
        end
        // Level 0 mask can never be beaten, so it blocks every request
        d.irq_take = irq_req && q.condition_flags[CCR_I] &&
            (irq_level < q.condition_flags[CCR_IL_HI:CCR_IL_LO]);
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            q <= '{ip: WORD_RESET, acc: WORD_RESET, tmp: WORD_RESET, idx: WORD_RESET,
                ext: WORD_RESET, sp: WORD_RESET, rp: RP_RESET, dp: DP_RESET,
                condition_flags: CCR_RESET, mem_addr: WORD_RESET, mem_valid: 1'b0,
                region: REGION_IO, irq_take: 1'b0, prdata: 32'h00000000,
                pready: 1'b0, pslverr: 1'b0};
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register
    assign instruction_pointer = q.ip;
    assign accumulator = q.acc;
    assign temp_accumulator = q.tmp;
    assign index_register = q.idx;
    assign extra_pointer = q.ext;
    assign stack_pointer = q.sp;
    assign program_status = {q.rp, q.dp, q.condition_flags};
    assign mem_addr = q.mem_addr;
    assign mem_addr_valid = q.mem_valid;
    assign mem_region = q.region;
    assign irq_take = q.irq_take;
    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence s_setup;
        psel && !penable;
    endsequence

    sequence s_direct_high;
        addr_req && addr_direct && (addr_operand >= DIRECT_WINDOW);
    endsequence

    sequence s_byte_add;
        alu_commit && !alu_wide && (alu_op == ALU_ADD);
    endsequence

    AST_APB_ANSWER: assert property (s_setup |=> pready && !$past(pready))
        else $error("pready not high in the first access cycle");

    AST_DIRECT_LOW: assert property (
        addr_req && addr_direct && (addr_operand < DIRECT_WINDOW)
        |=> mem_addr_valid && mem_addr == {8'h00, $past(addr_operand)})
        else $error("low direct address was remapped");

    AST_DIRECT_MAP: assert property (
        s_direct_high |=> mem_addr[15:7] == {5'h00, {1'b0, $past(q.dp)} + PAGE_STEP}
        && mem_addr[6:0] == $past(addr_operand[6:0]))
        else $error("direct page window mapped to wrong region");

    AST_REG_ADDR: assert property (
        addr_req && !addr_direct
        |=> mem_addr == {BANK_BASE_HI, $past(q.rp), $past(addr_operand[2:0])})
        else $error("bank register address formed wrongly");

    AST_IRQ_ENABLE: assert property (irq_take |-> $past(q.condition_flags[CCR_I]) && $past(irq_req))
        else $error("interrupt taken while disabled");

    AST_IRQ_LEVEL: assert property (
        irq_take |-> $past(irq_level) < $past(q.condition_flags[CCR_IL_HI:CCR_IL_LO]))
        else $error("interrupt taken at a masked level");

    AST_CARRY8: assert property (
        s_byte_add |=> q.condition_flags[CCR_C] == $past(sum_b[8]) && accumulator[7:0] == $past(sum_b[7:0]))
        else $error("byte carry or result wrong");

    AST_ZERO_NEG: assert property (
        s_byte_add |=> q.condition_flags[CCR_Z] == (accumulator[7:0] == 8'h00)
        && q.condition_flags[CCR_N] == accumulator[7])
        else $error("zero or negative flag wrong after byte add");

    AST_FLAGS_HOLD: assert property (
        !alu_commit && !(core_wr_en && core_wr_sel == SEL_PS) && !(apb_wr && paddr == OFS_PS)
        |=> $stable(q.condition_flags))
        else $error("flags changed without a completing operation");

    AST_IP_STEP: assert property (
        ip_step && !core_wr_en && !apb_wr |=> instruction_pointer == $past(q.ip) + 16'h0001)
        else $error("instruction pointer did not advance");

    AST_RESET_STATE: assert property (@(posedge clock) disable iff (1'b0)
        !rst_n |=> q.dp == DP_RESET && !q.condition_flags[CCR_I] && !irq_take)
        else $error("reset did not clear direct page and interrupt enable");

endmodule : crb_core_regs

// ---- src/crb_pkg.sv ----
// Purpose: Shared constants and types for the CPU register and bank addressing block.
// Assumes: One core clock; the decoder, the ALU and the APB master run on it.
// Notes: Program status layout is bank pointer [15:11], direct page [10:8], flags [7:0].
//
// Summary of operation
// - Classify each formed address into the I/O, data, program or vector area.
// - Keep a 16-bit instruction pointer for the next fetch location.
// - Keep a 16-bit accumulator; byte operations use and change only its low byte.
// - Keep a 16-bit temporary accumulator as second operand; bytes use its low byte.
// - Keep 16-bit index register, extra pointer and stack pointer.
// - Program status: bank pointer and direct page high, condition flags low.
// - Thirty-two banks of eight byte registers live in memory, chosen by bank pointer.
// - Low three opcode bits pick register zero to seven inside the active bank.
// - Direct addresses below 0x80 are never remapped, whatever the direct page.
// - Direct page resets to zero; zero leaves 0x80 to 0xFF at their own addresses.
// - Direct page 1 to 7 moves the upper window to 0x100 onward, up to 0x47F.
// - Half-carry flag shows carry or borrow between bit 3 and bit 4.
// - Interrupts are taken only while the enable flag is one; reset clears it.
// - Two-bit level mask; a request is taken only if its level is more urgent.
// - Negative flag follows the most significant bit of each result.
// - Zero flag is set when the result is zero, cleared otherwise.
// - Overflow flag shows two's-complement overflow of the result.
// - Carry takes carry or borrow out of bit 7, or bit 15 for word operations; shifts put the shifted-out bit there.

package crb_pkg;

    // ----------------------------------------------------------------
    // Program status layout and reset
    // ----------------------------------------------------------------
    localparam int unsigned CCR_H = 7;
    localparam int unsigned CCR_I = 6;
    localparam int unsigned CCR_IL_HI = 5;
    localparam int unsigned CCR_IL_LO = 4;
    localparam int unsigned CCR_N = 3;
    localparam int unsigned CCR_Z = 2;
    localparam int unsigned CCR_V = 1;
    localparam int unsigned CCR_C = 0;
    localparam logic [7:0] CCR_RESET = 8'h30;      // Enable clear (nothing taken), level 3
    localparam logic [4:0] RP_RESET = 5'h00;
    localparam logic [2:0] DP_RESET = 3'h0;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [1:0] IL_NONE = 2'h3;

    // ----------------------------------------------------------------
    // Address map
    // ----------------------------------------------------------------
    localparam logic [7:0] BANK_BASE_HI = 8'h01;    // Banks fill 0x0100 to 0x01FF
    localparam logic [7:0] DIRECT_WINDOW = 8'h80;   // First remappable direct address
    localparam logic [3:0] PAGE_STEP = 4'h1;
    localparam logic [15:0] IO_TOP = 16'h007F;
    localparam logic [15:0] VECTOR_BASE = 16'hFFC0;

    // ----------------------------------------------------------------
    // APB register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_IP = 8'h00;
    localparam logic [7:0] OFS_ACC = 8'h04;
    localparam logic [7:0] OFS_TMP = 8'h08;
    localparam logic [7:0] OFS_IDX = 8'h0C;
    localparam logic [7:0] OFS_EXT = 8'h10;
    localparam logic [7:0] OFS_SP = 8'h14;
    localparam logic [7:0] OFS_PS = 8'h18;
    localparam logic [7:0] OFS_LAST = 8'h1C;        // Read only: last formed address
    localparam logic [15:0] ZERO16 = 16'h0000;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {SEL_IP, SEL_ACC, SEL_TMP, SEL_IDX, SEL_EXT, SEL_SP,
        SEL_PS} crb_sel_t;
    typedef enum logic [1:0] {ALU_ADD, ALU_SUB, ALU_SHL, ALU_SHR} crb_alu_t;
    typedef enum logic [1:0] {REGION_IO, REGION_DATA, REGION_PROG, REGION_VECT} crb_region_t;

    typedef struct packed {
        logic [15:0] ip;
        logic [15:0] acc;
        logic [15:0] tmp;
        logic [15:0] idx;
        logic [15:0] ext;
        logic [15:0] sp;
        logic [4:0] rp;
        logic [2:0] dp;
        logic [7:0] condition_flags;
        logic [15:0] mem_addr;
        logic mem_valid;
        crb_region_t region;
        logic irq_take;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } crb_state_t;

endpackage : crb_pkg

// ---- test/cpu_register_and_bank_addressing_tb.sv ----
// Purpose: Self-checking bench for the core register and bank addressing block.
// Assumes: APB answers with zero wait states, but the bench waits on pready anyway.
// Notes: Random stimulus from a fixed seed, with boundary operands mixed in.

module cpu_register_and_bank_addressing_tb
    import crb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clock, rst_n, psel, penable, pwrite, pready, pslverr, err, dr;
    logic core_wr_en, ip_step, alu_commit, alu_wide, addr_req, addr_direct;
    logic irq_req, irq_take, mem_addr_valid;
    logic [7:0] paddr, addr_operand, seen_count, op, f;
    logic [31:0] pwdata, prdata, rd, d;
    logic [15:0] core_wr_data, instruction_pointer, accumulator, temp_accumulator;
    logic [15:0] index_register, extra_pointer, stack_pointer, program_status;
    logic [15:0] mem_addr, seen_addr, a, t, e;
    logic [23:0] x;
    logic [4:0] rp;
    logic [2:0] dp;
    logic [1:0] irq_level;
    crb_sel_t core_wr_sel;
    crb_alu_t alu_op;
    crb_region_t mem_region, seen_region;
    int bad_count, checked, cycles, seed, k;

    crb_core_regs #(.PROG_BASE(16'h1000)) u_crb_core_regs (.clock, .rst_n, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .core_wr_en, .core_wr_sel,
        .core_wr_data, .ip_step, .alu_commit, .alu_op, .alu_wide, .addr_req, .addr_direct,
        .addr_operand, .irq_req, .irq_level, .instruction_pointer, .accumulator,
        .temp_accumulator, .index_register, .extra_pointer, .stack_pointer, .program_status,
        .mem_addr, .mem_addr_valid, .mem_region, .irq_take);
    crb_mem_model u_crb_mem_model (.clock, .rst_n, .mem_addr, .mem_addr_valid, .mem_region,
        .seen_addr, .seen_region, .seen_count);

    // Clock and hang guard; a run this short never nears the ceiling
    always #50 clock = ~clock;
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count++;
            summarize();
        end
    end

    // ------------------------------------------------------------
    // Tasks and expectations
    // ------------------------------------------------------------
    task check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // Request held until pready is seen high at an edge, then released
    task apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) bad_count++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task core(input crb_sel_t s, input logic [15:0] wd);
        @(posedge clock);
        core_wr_en <= 1'b1;
        core_wr_sel <= s;
        core_wr_data <= wd;
        @(posedge clock);
        core_wr_en <= 1'b0;
    endtask : core
    function automatic logic [15:0] exp_addr(input logic di, input logic [7:0] o,
        input logic [4:0] r, input logic [2:0] p);
        if (!di) return {BANK_BASE_HI, r, o[2:0]};
        if (o < DIRECT_WINDOW) return {8'h00, o};
        return {5'h00, {1'b0, p} + 4'h1, o[6:0]};
    endfunction : exp_addr
    // Returns {flags, accumulator}; shifts are byte wide whatever the width flag says
    function automatic logic [23:0] alu_exp(input logic [1:0] o, input logic w,
        input logic [15:0] aa, input logic [15:0] tt, input logic [7:0] fl);
        logic [16:0] s;
        logic [15:0] r;
        logic ww, h, c, n, z, v, ma, mt;
        ww = w && !o[1];
        h = fl[CCR_H];
        s = ww ? {1'b0, aa} + {1'b0, tt} : {9'h000, aa[7:0]} + {9'h000, tt[7:0]};
        if (o == 2'h0) h = ({1'b0, aa[3:0]} + {1'b0, tt[3:0]}) > 5'h0F;
        if (o == 2'h1) s = ww ? {1'b0, aa} - {1'b0, tt} : {9'h000, aa[7:0]} - {9'h000, tt[7:0]};
        if (o == 2'h1) h = aa[3:0] < tt[3:0];
        if (o == 2'h2) s = {8'h00, aa[7:0], 1'b0};
        if (o == 2'h3) s = {10'h000, aa[7:1]};
        r = ww ? s[15:0] : {aa[15:8], s[7:0]};
        c = (o == 2'h3) ? aa[0] : (ww ? s[16] : s[8]);
        n = ww ? r[15] : r[7];
        z = ww ? (r == 16'h0000) : (r[7:0] == 8'h00);
        ma = ww ? aa[15] : aa[7];
        mt = ww ? tt[15] : tt[7];
        v = !o[1] && (n != ma) && ((o == 2'h0) ? (ma == mt) : (ma != mt));
        return {h, fl[6:4], n, z, v, c, r};
    endfunction : alu_exp

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {clock, rst_n, psel, penable, pwrite, core_wr_en, ip_step, alu_commit} = 8'h00;
        {alu_wide, addr_req, addr_direct, irq_req, irq_level} = 6'h00;
        {paddr, addr_operand, pwdata, core_wr_data} = 64'h0;
        core_wr_sel = SEL_IP;
        alu_op = ALU_ADD;
        {bad_count, checked, cycles} = 96'h0;
        seed = 32498;
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        // Reset view of every register, last-address word included
        for (k = 0; k < 8; k++) begin
            apb(1'b0, 8'(k * 4), 32'h0);
            check(rd, (k == 6) ? 32'h0000_0030 : 32'h0);
        end
        $display("test reset done");
        // Write and read back each writable register; upper half must read zero
        for (k = 0; k < 7; k++) begin
            d = $random(seed);
            apb(1'b1, 8'(k * 4), d);
            apb(1'b0, 8'(k * 4), 32'h0);
            check(rd, {16'h0000, d[15:0]});
        end
        check(program_status, d[15:0]);
        apb(1'b1, OFS_LAST, 32'h0);
        check(err, 32'h1);
        apb(1'b0, 8'h02, 32'h0);
        check(err, 32'h1);
        core(SEL_IP, 16'hFFFF);
        @(posedge clock) ip_step <= 1'b1;
        @(posedge clock) ip_step <= 1'b0;
        @(negedge clock) check(instruction_pointer, 32'h0);
        $display("test registers done");
        // Bank and direct addresses across every page, both sides of 0x80
        for (k = 0; k < 48; k++) begin
            d = $random(seed);
            {rp, op} = d[12:0];
            dp = 3'(k % 8);
            dr = (k % 3) != 0;
            if (k < 16) op = k[3] ? 8'h80 : 8'h7F;
            core(SEL_PS, {rp, dp, 8'h30});
            @(posedge clock) {addr_req, addr_direct, addr_operand} <= {1'b1, dr, op};
            @(posedge clock) addr_req <= 1'b0;
            @(posedge clock);
            @(negedge clock);
            e = exp_addr(dr, op, rp, dp);
            check(seen_addr, e);
            check(seen_region, (e <= IO_TOP) ? REGION_IO : REGION_DATA);
        end
        check(seen_count, 32'h30);
        $display("test addressing done");
        // Every operation in both widths, random operands and flags
        for (k = 0; k < 48; k++) begin
            {a, t} = $random(seed);
            {rp, dp, f} = $random(seed);
            if (k < 8) {a, t} = {16'h80FF, 16'h0001};
            if (k >= 8 && k < 12) t = a;
            core(SEL_ACC, a);
            core(SEL_TMP, t);
            core(SEL_PS, {rp, dp, f});
            @(posedge clock);
            // Enum target kept out of the concatenation so the cast is explicit
            alu_op <= crb_alu_t'(2'(k % 4));
            {alu_commit, alu_wide} <= {1'b1, k[2]};
            @(posedge clock) alu_commit <= 1'b0;
            @(negedge clock);
            x = alu_exp(2'(k % 4), k[2], a, t, f);
            check(accumulator, x[15:0]);
            check(program_status, {rp, dp, x[23:16]});
        end
        $display("test arithmetic done");
        // Enable flag, mask level and request level in all combinations
        for (k = 0; k < 32; k++) begin
            core(SEL_PS, {9'h000, k[4], k[3:2], 4'h0});
            @(posedge clock) {irq_req, irq_level} <= {1'b1, k[1:0]};
            @(posedge clock) irq_req <= 1'b0;
            @(negedge clock) check(irq_take, k[4] && (k[1:0] < k[3:2]));
        end
        $display("test interrupts done");
        summarize();
    end

    task summarize();
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : summarize
endmodule : cpu_register_and_bank_addressing_tb

// ---- test/crb_mem_model.sv ----
// Purpose: Memory bus model that captures each address the register block forms.
// Assumes: One core clock; a formed address is valid for exactly one cycle.
// Notes: Counts valid pulses, so a stuck or doubled pulse shows in the count.

module crb_mem_model
    import crb_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [15:0] mem_addr,
    input wire logic mem_addr_valid,
    input wire crb_region_t mem_region,
    output logic [15:0] seen_addr,
    output crb_region_t seen_region,
    output logic [7:0] seen_count
);
    // ------------------------------------------------------------
    // Capture
    // ------------------------------------------------------------
    // Take the bus only on valid; a lingering valid would inflate the count
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            seen_addr <= ZERO16;
            seen_region <= REGION_IO;
            seen_count <= 8'h00;
        end else if (mem_addr_valid) begin
            seen_addr <= mem_addr;
            seen_region <= mem_region;
            seen_count <= seen_count + 8'h01;
        end
    end
endmodule : crb_mem_model
